// [pkg/pdr_pkg.sv]
// Package for the PHY I/O configuration and cable diagnostic register slice.
// Assumes a 16-bit register port decoded by the management front end.
package pdr_pkg;

  // Register addresses
  localparam logic [9:0] PDR_ADDR_AMP2  = 10'h186;
  localparam logic [9:0] PDR_ADDR_AMP3  = 10'h187;
  localparam logic [9:0] PDR_ADDR_AMP4  = 10'h188;
  localparam logic [9:0] PDR_ADDR_AMP5  = 10'h189;
  localparam logic [9:0] PDR_ADDR_AMP6  = 10'h18a;
  localparam logic [9:0] PDR_ADDR_IOCFG = 10'h302;
  localparam logic [9:0] PDR_ADDR_SPARE = 10'h308;

  // Field positions
  localparam int PDR_AMP6_SIGN_BIT  = 11;
  localparam int PDR_AMP6_SHORT_BIT = 5;
  localparam int PDR_IO_TERM_LSB    = 14;
  localparam int PDR_IO_CLKOFF_BIT  = 6;
  localparam int PDR_IO_MFP_LSB     = 0;
  localparam int PDR_SP_STATE_BIT   = 0;
  localparam int PDR_SP_REV_BIT     = 1;
  localparam int PDR_SP_RXCLK_BIT   = 2;
  localparam int PDR_SP_DISFRZ_BIT  = 4;
  localparam int PDR_SP_MSEBYP_BIT  = 5;
  localparam int PDR_SP_STFRZ_BIT   = 6;
  localparam int PDR_SP_CNTFRZ_BIT  = 7;
  localparam int PDR_SP_TSEL_BIT    = 8;
  localparam int PDR_SP_WAIT_LSB    = 10;

  // Writable masks and reset values
  localparam logic [15:0] PDR_IO_WMASK    = 16'hc047;
  localparam logic [15:0] PDR_SP_WMASK    = 16'hfdf4;
  localparam logic [15:0] PDR_IO_RESET    = 16'h0000;
  localparam logic [15:0] PDR_SP_RESET    = 16'h0000;
  // Revision indicator value, arbitrary
  localparam logic        PDR_REV_VALUE   = 1'b0;

  // Termination encodings
  localparam logic [1:0] PDR_TERM_50 = 2'h0;
  localparam logic [1:0] PDR_TERM_25 = 2'h1;

  // Freeze timer lengths
  localparam int PDR_CLK_MHZ     = 10;
  localparam int PDR_FRZ_SHORT_US = 176;
  localparam int PDR_FRZ_LONG_US  = 192;
  localparam int PDR_FRZ_SHORT_CYC = PDR_FRZ_SHORT_US * PDR_CLK_MHZ;
  localparam int PDR_FRZ_LONG_CYC  = PDR_FRZ_LONG_US * PDR_CLK_MHZ;

  typedef enum logic [2:0] {
    PDR_MFP_HALF_CLK, PDR_MFP_LED2, PDR_MFP_WOL, PDR_MFP_LOW3,
    PDR_MFP_MANAGEMENT_INTERRUPT_OUTPUT, PDR_MFP_LOW5, PDR_MFP_HIGH, PDR_MFP_LOW7
  } pdr_mfp_t;

  // Six loop freeze outputs in wait state
  typedef struct packed {
    logic dc_removal;
    logic integral_timing_loop;
    logic proportional_timing_loop;
    logic dfe;
    logic ffe;
    logic fine_gain;
  } pdr_loops_t;

  typedef struct packed {
    logic       idle_wake_state;
    logic       settled_state;
    logic       idle_hold_state;
    logic       idle_wait_state;
    logic       idle_refresh;
    logic       receiver_disabled_flag;
  } pdr_rx_state_t;

endpackage

// [design/pdr_regs.sv]
// Register slice: cable diagnostic results, pin I/O config, spare controls.
// Assumes a one-cycle read/write strobe register port in the clock domain.
`timescale 1ns/1ps

module pdr_regs
  import pdr_pkg::*;
#(
  parameter int FRZ_SHORT_CYC = pdr_pkg::PDR_FRZ_SHORT_CYC,
  parameter int FRZ_LONG_CYC  = pdr_pkg::PDR_FRZ_LONG_CYC
) (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  // Register port
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  input  wire logic [9:0]             reg_addr_i,
  input  wire logic [15:0]            reg_wdata_i,
  output logic      [15:0]            reg_rdata_o,
  // Diagnostic engine results
  input  wire logic                   first_peak_sign_i,
  input  wire logic                   transmit_pair_short_flag_i,
  // Pin sources
  input  wire logic                   quarter_clock_i,
  input  wire logic                   half_clock_i,
  input  wire logic                   master_mode_i,
  input  wire logic                   second_indicator_i,
  input  wire logic                   wake_on_lan_i,
  input  wire logic                   management_interrupt_i,
  input  wire logic                   pad_three_gp_control_i,
  // Receive state
  input  wire pdr_pkg::pdr_rx_state_t rx_state_i,
  // Pin and analog controls
  output logic                        quarter_clock_output_o,
  output logic                        first_indicator_gp_pin_o,
  output logic                        multi_function_pin_o,
  output logic      [1:0]             host_pin_termination_select_o,
  output logic                        rmii_rx_clk_select_o,
  output logic                        mean_square_error_bypass_o,
  output pdr_pkg::pdr_loops_t         loop_freeze_o
);

  initial begin
    if (FRZ_SHORT_CYC < 1 || FRZ_LONG_CYC < FRZ_SHORT_CYC || FRZ_LONG_CYC > 65535) begin
      $error("pdr_regs: freeze timer lengths out of range");
    end
  end

  typedef struct packed {
    logic [15:0] io_cfg;
    logic [15:0] spare;
    logic        peak_sign;
    logic        short_flag;
    logic [15:0] rdata;
    logic [15:0] frz_cnt;
    logic        refresh_prev;
    logic        qclk;
    logic        gp_pin;
    logic        mfp;
    logic [1:0]  term;
    logic        rxclk;
    logic        msebyp;
    pdr_loops_t  frz;
  } pdr_state_t;

  pdr_state_t s_q, s_d;

  function automatic logic mfp_decode(input logic [2:0] sel, input logic hc, input logic mm,
                                      input logic led2, input logic wake_on_lan_output, input logic mdi);
    logic r;
    r = 1'b0;
    unique case (pdr_mfp_t'(sel))
      PDR_MFP_HALF_CLK: r = hc & mm;
      PDR_MFP_LED2:     r = led2;
      PDR_MFP_WOL:      r = wake_on_lan_output;
      PDR_MFP_MANAGEMENT_INTERRUPT_OUTPUT:    r = mdi;
      PDR_MFP_HIGH:     r = 1'b1;
      PDR_MFP_LOW3, PDR_MFP_LOW5, PDR_MFP_LOW7: r = 1'b0;
    endcase
    return r;
  endfunction

  logic        clk_off;
  logic [15:0] spare_view;
  logic        timer_run;
  logic        all_freeze;
  logic        wait_frz_en;
  logic [5:0]  wait_bits;

  always_comb begin
    s_d = s_q;
    clk_off = s_q.io_cfg[PDR_IO_CLKOFF_BIT];
    spare_view = s_q.spare & PDR_SP_WMASK;
    spare_view[PDR_SP_STATE_BIT] = clk_off;
    spare_view[PDR_SP_REV_BIT] = PDR_REV_VALUE;

    if (reg_wr_i && reg_addr_i == PDR_ADDR_IOCFG) begin
      s_d.io_cfg = reg_wdata_i & PDR_IO_WMASK;
    end
    if (reg_wr_i && reg_addr_i == PDR_ADDR_SPARE) begin
      s_d.spare = reg_wdata_i & PDR_SP_WMASK;
    end

    s_d.peak_sign  = first_peak_sign_i;
    s_d.short_flag = transmit_pair_short_flag_i;

    if (reg_rd_i) begin
      s_d.rdata = 16'h0000;
      unique case (reg_addr_i)
        PDR_ADDR_AMP6: begin
          s_d.rdata[PDR_AMP6_SIGN_BIT]  = s_q.peak_sign;
          s_d.rdata[PDR_AMP6_SHORT_BIT] = s_q.short_flag;
        end
        PDR_ADDR_IOCFG: s_d.rdata = s_q.io_cfg;
        PDR_ADDR_SPARE: s_d.rdata = spare_view;
        default: s_d.rdata = 16'h0000;
      endcase
    end

    s_d.qclk   = ~clk_off & quarter_clock_i;
    s_d.gp_pin = clk_off & pad_three_gp_control_i;
    s_d.mfp = mfp_decode(s_q.io_cfg[PDR_IO_MFP_LSB +: 3], half_clock_i, master_mode_i,
                         second_indicator_i, wake_on_lan_i, management_interrupt_i);
    s_d.term = s_q.io_cfg[PDR_IO_TERM_LSB +: 2];
    s_d.rxclk = s_q.spare[PDR_SP_RXCLK_BIT];
    s_d.msebyp = s_q.spare[PDR_SP_MSEBYP_BIT] & rx_state_i.idle_wake_state;

    // refresh freeze timer, restarted on refresh entry
    s_d.refresh_prev = rx_state_i.idle_refresh;
    if (s_q.spare[PDR_SP_CNTFRZ_BIT] && rx_state_i.idle_refresh && !s_q.refresh_prev) begin
      s_d.frz_cnt = s_q.spare[PDR_SP_TSEL_BIT] ? 16'(FRZ_LONG_CYC) : 16'(FRZ_SHORT_CYC);
    end else if (s_q.frz_cnt != 16'h0000) begin
      s_d.frz_cnt = s_q.frz_cnt - 16'h0001;
    end
    timer_run = (s_q.frz_cnt != 16'h0000);

    all_freeze = (s_q.spare[PDR_SP_DISFRZ_BIT] & rx_state_i.receiver_disabled_flag)
               | (s_q.spare[PDR_SP_STFRZ_BIT] & rx_state_i.settled_state)
               | timer_run;
    wait_frz_en = rx_state_i.idle_wait_state;
    wait_bits = s_q.spare[PDR_SP_WAIT_LSB +: 6] & {6{wait_frz_en}};
    s_d.frz = pdr_loops_t'(wait_bits | {6{all_freeze}});

    if (rst_i) begin
      s_d = '0;
      s_d.io_cfg = PDR_IO_RESET;
      s_d.spare  = PDR_SP_RESET;
    end
  end

  always_ff @(posedge clock_i) begin
    s_q <= s_d;
  end

  assign reg_rdata_o                   = s_q.rdata;
  assign quarter_clock_output_o        = s_q.qclk;
  assign first_indicator_gp_pin_o      = s_q.gp_pin;
  assign multi_function_pin_o          = s_q.mfp;
  assign host_pin_termination_select_o = s_q.term;
  assign rmii_rx_clk_select_o          = s_q.rxclk;
  assign mean_square_error_bypass_o    = s_q.msebyp;
  assign loop_freeze_o                 = s_q.frz;

  // Assertions
  property p_mfp_high;
    @(posedge clock_i) disable iff (rst_i)
      (s_q.io_cfg[2:0] == 3'h6) ##1 (s_q.io_cfg[2:0] == 3'h6) |-> multi_function_pin_o;
  endproperty
  a_mfp_high: assert property (p_mfp_high) else $error("selector 6 not high");

  property p_mfp_low;
    @(posedge clock_i) disable iff (rst_i)
      (s_q.io_cfg[2:0] == 3'h3) |=> !multi_function_pin_o;
  endproperty
  a_mfp_low: assert property (p_mfp_low) else $error("selector 3 not low");

  property p_qclk_off;
    @(posedge clock_i) disable iff (rst_i)
      s_q.io_cfg[PDR_IO_CLKOFF_BIT] |=> !quarter_clock_output_o;
  endproperty
  a_qclk_off: assert property (p_qclk_off) else $error("quarter clock not gated");

  sequence s_rd_spare;
    reg_rd_i && reg_addr_i == PDR_ADDR_SPARE && !reg_wr_i;
  endsequence
  property p_state_mirror;
    @(posedge clock_i) disable iff (rst_i)
      s_rd_spare |=> reg_rdata_o[0] == $past(s_q.io_cfg[PDR_IO_CLKOFF_BIT]);
  endproperty
  a_state_mirror: assert property (p_state_mirror) else $error("state bit mismatch");

  property p_rev_fixed;
    @(posedge clock_i) disable iff (rst_i)
      s_rd_spare |=> reg_rdata_o[PDR_SP_REV_BIT] == PDR_REV_VALUE;
  endproperty
  a_rev_fixed: assert property (p_rev_fixed) else $error("revision bit changed");

  property p_term;
    @(posedge clock_i) disable iff (rst_i)
      1'b1 |=> host_pin_termination_select_o == $past(s_q.io_cfg[15:14]);
  endproperty
  a_term: assert property (p_term) else $error("termination not following field");

  property p_amp_rsvd;
    @(posedge clock_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i >= PDR_ADDR_AMP2 && reg_addr_i <= PDR_ADDR_AMP5
        |=> reg_rdata_o == 16'h0000;
  endproperty
  a_amp_rsvd: assert property (p_amp_rsvd) else $error("reserved register not zero");

  property p_short_flag;
    @(posedge clock_i) disable iff (rst_i)
      transmit_pair_short_flag_i ##1 (reg_rd_i && reg_addr_i == PDR_ADDR_AMP6)
        |=> reg_rdata_o[PDR_AMP6_SHORT_BIT];
  endproperty
  a_short_flag: assert property (p_short_flag) else $error("short flag lost");

  property p_dis_freeze;
    @(posedge clock_i) disable iff (rst_i)
      s_q.spare[PDR_SP_DISFRZ_BIT] && rx_state_i.receiver_disabled_flag
        |=> loop_freeze_o == 6'h3f;
  endproperty
  a_dis_freeze: assert property (p_dis_freeze) else $error("loops not frozen");

  property p_timer_len;
    @(posedge clock_i) disable iff (rst_i)
      s_q.spare[PDR_SP_CNTFRZ_BIT] && !s_q.spare[PDR_SP_TSEL_BIT]
        && rx_state_i.idle_refresh && !s_q.refresh_prev
        |=> s_q.frz_cnt == 16'(FRZ_SHORT_CYC);
  endproperty
  a_timer_len: assert property (p_timer_len) else $error("freeze timer length wrong");

  property p_timer_long;
    @(posedge clock_i) disable iff (rst_i)
      s_q.spare[PDR_SP_CNTFRZ_BIT] && s_q.spare[PDR_SP_TSEL_BIT]
        && rx_state_i.idle_refresh && !s_q.refresh_prev
        |=> s_q.frz_cnt == 16'(FRZ_LONG_CYC);
  endproperty
  a_timer_long: assert property (p_timer_long) else $error("long freeze length wrong");

  property p_timer_freeze;
    @(posedge clock_i) disable iff (rst_i)
      s_q.frz_cnt != 16'h0000 |=> loop_freeze_o == 6'h3f;
  endproperty
  a_timer_freeze: assert property (p_timer_freeze) else $error("timed freeze missing");

  sequence s_rd_amp6;
    reg_rd_i && reg_addr_i == PDR_ADDR_AMP6;
  endsequence
  property p_peak_sign;
    @(posedge clock_i) disable iff (rst_i)
      first_peak_sign_i ##1 s_rd_amp6 |=> reg_rdata_o[PDR_AMP6_SIGN_BIT];
  endproperty
  a_peak_sign: assert property (p_peak_sign) else $error("peak sign lost");

  property p_gp_pin;
    @(posedge clock_i) disable iff (rst_i)
      s_q.io_cfg[PDR_IO_CLKOFF_BIT] && pad_three_gp_control_i |=> first_indicator_gp_pin_o;
  endproperty
  a_gp_pin: assert property (p_gp_pin) else $error("gp pin not following pad");

  property p_qclk_on;
    @(posedge clock_i) disable iff (rst_i)
      !s_q.io_cfg[PDR_IO_CLKOFF_BIT] && quarter_clock_i |=> quarter_clock_output_o;
  endproperty
  a_qclk_on: assert property (p_qclk_on) else $error("quarter clock not driven");

  property p_rxclk;
    @(posedge clock_i) disable iff (rst_i)
      1'b1 |=> rmii_rx_clk_select_o == $past(s_q.spare[PDR_SP_RXCLK_BIT]);
  endproperty
  a_rxclk: assert property (p_rxclk) else $error("receive clock select wrong");

  property p_mse_bypass;
    @(posedge clock_i) disable iff (rst_i)
      s_q.spare[PDR_SP_MSEBYP_BIT] && rx_state_i.idle_wake_state |=> mean_square_error_bypass_o;
  endproperty
  a_mse_bypass: assert property (p_mse_bypass) else $error("checker not bypassed");

  property p_mse_idle;
    @(posedge clock_i) disable iff (rst_i)
      !rx_state_i.idle_wake_state |=> !mean_square_error_bypass_o;
  endproperty
  a_mse_idle: assert property (p_mse_idle) else $error("bypass outside wake");

  property p_settled_freeze;
    @(posedge clock_i) disable iff (rst_i)
      s_q.spare[PDR_SP_STFRZ_BIT] && rx_state_i.settled_state |=> loop_freeze_o == 6'h3f;
  endproperty
  a_settled_freeze: assert property (p_settled_freeze) else $error("settled freeze off");

  property p_wait_freeze;
    @(posedge clock_i) disable iff (rst_i)
      rx_state_i.idle_wait_state
        |=> (6'(loop_freeze_o) & $past(s_q.spare[PDR_SP_WAIT_LSB +: 6]))
            == $past(s_q.spare[PDR_SP_WAIT_LSB +: 6]);
  endproperty
  a_wait_freeze: assert property (p_wait_freeze) else $error("wait freeze missing");

  property p_mfp_led2;
    @(posedge clock_i) disable iff (rst_i)
      (s_q.io_cfg[2:0] == 3'h1) && second_indicator_i |=> multi_function_pin_o;
  endproperty
  a_mfp_led2: assert property (p_mfp_led2) else $error("selector 1 not led");

  property p_mfp_wol;
    @(posedge clock_i) disable iff (rst_i)
      (s_q.io_cfg[2:0] == 3'h2) |=> multi_function_pin_o == $past(wake_on_lan_i);
  endproperty
  a_mfp_wol: assert property (p_mfp_wol) else $error("selector 2 not wake");

  property p_io_rsvd;
    @(posedge clock_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == PDR_ADDR_IOCFG |=> (s_q.io_cfg & ~PDR_IO_WMASK) == 16'h0000;
  endproperty
  a_io_rsvd: assert property (p_io_rsvd) else $error("reserved io bit stored");

endmodule

// [tb/pdr_host.sv]
// Management host model driving one-cycle register strobes.
// Assumes the register slice samples its strobes on the rising edge.
`timescale 1ns/1ps
module pdr_host (
  // Clock
  input  wire logic        clock_i,
  // Register strobes
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [9:0]       reg_addr_o,
  output logic [15:0]      reg_wdata_o
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 10'h000;
    reg_wdata_o = 16'h0000;
  end

  // Released bus shows inverted values so stale data never passes
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [15:0] d);
    @(negedge clock_i);
    reg_wr_o    = wr;
    reg_rd_o    = ~wr;
    reg_addr_o  = a;
    reg_wdata_o = d;
    @(negedge clock_i);
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask
endmodule

// [tb/pdr_regs_bench.sv]
// Self-checking bench for the register slice.
// Assumes the host model drives strobes; bench drives all other inputs.
`timescale 1ns/1ps
module pdr_regs_bench;
  import pdr_pkg::*;
  localparam int SHORT_N = 5;
  localparam int LONG_N  = 8;
  logic                  clock_i, rst_i, reg_wr_i, reg_rd_i, rd_seen;
  logic        [9:0]     reg_addr_i;
  logic        [15:0]    reg_wdata_i, reg_rdata_o;
  logic                  peak, tx_short, quarter, half, master, led2, wake_on_lan_output, management_interrupt_output, pad;
  logic                  qco, fip, mfp, rmii, mean_square_error_checker, e;
  logic        [1:0]     term;
  pdr_loops_t            lf;
  pdr_rx_state_t         rx;
  logic        [31:0]    rng, r;
  logic        [15:0]    exp_q[$];
  int                    errors, compares, n;
  logic        [9:0]     addrs [9] = '{PDR_ADDR_AMP2, PDR_ADDR_AMP3, PDR_ADDR_AMP4,
    PDR_ADDR_AMP5, PDR_ADDR_AMP6, PDR_ADDR_IOCFG, PDR_ADDR_SPARE, 10'h185, 10'h000};
  logic        [15:0]    wexp  [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'hc047, 16'hfdf5, 16'h0000, 16'h0000};

  pdr_host i_host (.clock_i(clock_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));

  pdr_regs #(.FRZ_SHORT_CYC(SHORT_N), .FRZ_LONG_CYC(LONG_N)) i_dut (
    .clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .first_peak_sign_i(peak), .transmit_pair_short_flag_i(tx_short),
    .quarter_clock_i(quarter), .half_clock_i(half), .master_mode_i(master),
    .second_indicator_i(led2), .wake_on_lan_i(wake_on_lan_output), .management_interrupt_i(management_interrupt_output),
    .pad_three_gp_control_i(pad), .rx_state_i(rx), .quarter_clock_output_o(qco),
    .first_indicator_gp_pin_o(fip), .multi_function_pin_o(mfp),
    .host_pin_termination_select_o(term), .rmii_rx_clk_select_o(rmii),
    .mean_square_error_bypass_o(mean_square_error_checker), .loop_freeze_o(lf));

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  function automatic logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    i_host.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [9:0] a, input logic [15:0] x);
    exp_q.push_back(x);
    i_host.xfer(1'b0, a, 16'h0000);
  endtask

  task automatic settle();
    repeat (2) @(negedge clock_i);
  endtask

  task automatic stop_test();
    if (exp_q.size() != 0) errors++;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Read data lands one cycle after the read edge
  always @(posedge clock_i) rd_seen <= reg_rd_i;
  always @(negedge clock_i) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      chk(reg_rdata_o, exp_q.pop_front());
    end
  end

  initial begin
    #1_000_000;
    errors++;
    stop_test();
  end

  initial begin
    rng = 32'h0000_0030;
    {peak, tx_short, quarter, half, master, led2, wake_on_lan_output, management_interrupt_output, pad} = '0;
    rx = '0;
    rst_i = 1'b1;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    foreach (addrs[i]) rd(addrs[i], 16'h0000);
    foreach (addrs[i]) wr(addrs[i], 16'hffff);
    foreach (addrs[i]) rd(addrs[i], wexp[i]);
    for (int i = 0; i < 4; i++) begin
      {peak, tx_short} = 2'(i);
      rd(PDR_ADDR_AMP6, {4'h0, i[1], 5'h00, i[0], 5'h00});
    end
    for (int i = 0; i < 8; i++) begin
      r = nxt();
      wr(PDR_ADDR_IOCFG, {r[1:0], 7'h00, i[0], 6'h00});
      {pad, quarter} = r[3:2];
      settle();
      chk(16'(qco), 16'(r[2] & ~i[0]));
      chk(16'(fip), 16'(r[3] & i[0]));
      chk(16'(term), 16'(r[1:0]));
      rd(PDR_ADDR_SPARE, 16'hfdf4 | 16'(i[0]));
    end
    for (int s = 0; s < 8; s++) begin
      wr(PDR_ADDR_IOCFG, {13'h0000, 3'(s)});
      repeat (4) begin
        r = nxt();
        {half, master, led2, wake_on_lan_output, management_interrupt_output} = r[4:0];
        settle();
        case (s)
          0: e = half & master;
          1: e = led2;
          2: e = wake_on_lan_output;
          4: e = management_interrupt_output;
          6: e = 1'b1;
          default: e = 1'b0;
        endcase
        chk(16'(mfp), 16'(e));
      end
    end
    for (int i = 0; i < 8; i++) begin
      r = nxt();
      wr(PDR_ADDR_SPARE, {10'h000, r[1], 2'b00, r[0], 2'b00});
      rx.idle_wake_state = r[2];
      settle();
      chk(16'(rmii), 16'(r[0]));
      chk(16'(mean_square_error_checker), 16'(r[1] & r[2]));
    end
    rx = '0;
    for (int b = 0; b < 6; b++) begin
      r = nxt();
      wr(PDR_ADDR_SPARE, 16'h0400 << b);
      rx.idle_wait_state = r[0];
      settle();
      chk({10'h000, lf}, r[0] ? 16'h0001 << b : 16'h0000);
    end
    for (int k = 0; k < 4; k++) begin
      rx = '0;
      wr(PDR_ADDR_SPARE, k[0] ? 16'h0010 : 16'h0040);
      rx.receiver_disabled_flag = k[1];
      rx.settled_state = ~k[1];
      settle();
      chk({10'h000, lf}, (k[0] == k[1]) ? 16'h003f : 16'h0000);
    end
    for (int k = 0; k < 2; k++) begin
      rx = '0;
      wr(PDR_ADDR_SPARE, k[0] ? 16'h0180 : 16'h0080);
      settle();
      rx.idle_refresh = 1'b1;
      n = 0;
      repeat (12) begin
        @(negedge clock_i);
        if (lf === 6'h3f) n++;
      end
      chk(16'(n), k[0] ? 16'(LONG_N) : 16'(SHORT_N));
    end
    settle();
    stop_test();
  end
endmodule
